/* verilog/sep_pkg.sv */
// Purpose: Shared constants, types and helpers of the serial EEPROM port.
// Assumes: A 100 MHz system clock and a 128 x 16 storage array.
// Notes: In byte organisation an even byte sits in the low half of a word.
package sep_pkg;

  // ==========================================================================
  // Timing
  localparam int MCLK_NS = 10;
  localparam int T_PROG_MS = 10;
  localparam int NS_PER_MS = 1000000;
  // Longest programming time, rounded down to whole system clocks.
  localparam int PROG_CYC = T_PROG_MS * NS_PER_MS / MCLK_NS;
  localparam int PCNT_W = 20;

  // ==========================================================================
  // Frame fields
  localparam logic [4:0] OP_LEN = 5'h02;
  localparam logic [4:0] ALEN_WORD = 5'h08;
  localparam logic [4:0] ALEN_BYTE = 5'h09;
  localparam logic [4:0] DLEN_WORD = 5'h10;
  localparam logic [4:0] DLEN_BYTE = 5'h08;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DIS = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL_CMD = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] EXT_EN = 2'h3;

  // ==========================================================================
  // Array
  localparam logic [6:0] LAST_IDX = 7'h7f;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [1:0] BE_ALL = 2'h3;

  typedef enum logic [2:0] {
    K_EN, K_DIS, K_WRITE, K_ERASE, K_ERASE_ALL_CMD, K_WRITE_ALL_CMD
  } sep_kind_t;
  typedef enum logic [2:0] {
    L_IDLE, L_OP, L_ADDR, L_DATA, L_RDUM, L_RDAT, L_DONE
  } sep_lst_t;
  typedef enum logic [1:0] {M_IDLE, M_FILL, M_TIME} sep_mst_t;

  // Word index of a location in either organisation.
  function automatic logic [6:0] sep_idx(input logic word,
                                         input logic [7:0] a);
    return word ? a[6:0] : a[7:1];
  endfunction

  // Byte lanes touched by a single-location write or erase.
  function automatic logic [1:0] sep_be(input logic word,
                                        input logic [7:0] a);
    return word ? BE_ALL : (a[0] ? 2'h2 : 2'h1);
  endfunction

  // Write data spread over both lanes in byte organisation.
  function automatic logic [15:0] sep_wfmt(input logic word,
                                           input logic [15:0] d);
    return word ? d : {d[7:0], d[7:0]};
  endfunction

endpackage

/* verilog/sep_sync.sv */
// Purpose: Two-stage synchroniser for independent level signals.
// Assumes: Each bit is a slow level; bits are not sampled as one word.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/10ps
module sep_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;

  // ==========================================================================
  // Two flops in a row give a metastable first stage a full cycle to settle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= RST;
      q <= RST;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end

endmodule

/* verilog/sep_mem.sv */
// Purpose: 128 x 16 storage array with lane enables and a registered read.
// Assumes: One write and one read port, both on the system clock.
// Notes: Contents are not reset; nonvolatile data survive a logic reset.
`timescale 1ns/10ps
module sep_mem (
  input wire logic mclk,
  input wire logic we,
  input wire logic [1:0] be,
  input wire logic [6:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [6:0] raddr,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:127];

  // ==========================================================================
  // Lane-wise write; read data always come out of a register.
  always_ff @(posedge mclk) begin
    if (we && be[1]) begin
      mem[waddr][15:8] <= wdata[15:8];
    end
    if (we && be[0]) begin
      mem[waddr][7:0] <= wdata[7:0];
    end
    rdata <= mem[raddr];
  end

endmodule

/* verilog/sep_core.sv */
// Purpose: Serial command port of a 2K-bit EEPROM, decoder to array.
// Assumes: sclk is the host's serial clock and may stop between frames.
// Notes: Serial decode runs on sclk; array, timing and output on mclk.
`timescale 1ns/10ps
module sep_core
  import sep_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic chip_sel,
  input wire logic ser_in,
  input wire logic org_word,
  output logic ser_out,
  output logic ser_out_oe
);

  // ==========================================================================
  // Link side declarations (sclk domain)
  sep_lst_t lst_r, lst_nxt;
  logic [4:0] cnt_r, cnt_nxt, alen, dlen;
  logic [15:0] sh_r, sh_nxt, shin, ld;
  logic lq_r, lq_nxt, ldrv_r, ldrv_nxt;
  logic rreq_r, rreq_nxt, rorg_r, rorg_nxt, stgl_r, stgl_nxt;
  logic ctgl_r, ctgl_nxt, corg_r, corg_nxt;
  logic [7:0] raddr_r, raddr_nxt, caddr_r, caddr_nxt, ad;
  logic [15:0] cdata_r, cdata_nxt;
  sep_kind_t ckind_r, ckind_nxt;
  logic [1:0] op, ext;
  logic org_s, ack_n1_r, ack_n2_r, link_rst_n;

  // ==========================================================================
  // System side declarations (mclk domain)
  sep_mst_t mst_r, mst_nxt;
  logic [PCNT_W-1:0] pcnt_r, pcnt_nxt;
  logic [6:0] fill_r, fill_nxt, mem_wa, mem_ra;
  logic [15:0] fdata_r, fdata_nxt, rdata_r, rdata_nxt, mem_wd, mem_rd;
  logic [1:0] mem_be;
  logic mem_we, busy, done, cs_fall, cmd_ev, rd_ev, st_ev;
  logic cs_s, ctgl_s, rreq_s, stgl_s, lq_s, ldrv_s;
  logic cs_d_r, ctgl_d_r, rreq_d_r, stgl_d_r;
  logic prog_en_r, prog_en_nxt, armed_r, armed_nxt, ready_r, ready_nxt;
  logic rd_stage_r, rd_stage_nxt, ack_r, ack_nxt;
  logic q_r, q_nxt, oe_r, oe_nxt;

  // Frame state is cleared whenever select is low, so no sclk edge is
  // needed to end a frame.
  assign link_rst_n = arst_n & chip_sel;

  // The organisation strap is a pin, so it is resynchronised to sclk.
  sep_sync #(.W(1), .RST(1'b1)) u_org_sync (
    .clk(sclk),
    .arst_n(arst_n),
    .d(org_word),
    .q(org_s)
  );

  // ==========================================================================
  // Serial decoder: one bit per rising sclk edge while selected.
  always_comb begin
    shin = {sh_r[14:0], ser_in};
    alen = org_s ? ALEN_WORD : ALEN_BYTE;
    dlen = org_s ? DLEN_WORD : DLEN_BYTE;
    op = 2'(shin >> alen);
    ext = org_s ? shin[7:6] : shin[8:7];
    ad = org_s ? {1'b0, shin[6:0]} : shin[7:0];
    ld = rorg_r ? rdata_r : {rdata_r[7:0], 8'h00};
    lst_nxt = lst_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    lq_nxt = lq_r;
    ldrv_nxt = ldrv_r;
    rreq_nxt = rreq_r;
    raddr_nxt = raddr_r;
    rorg_nxt = rorg_r;
    stgl_nxt = stgl_r;
    ctgl_nxt = ctgl_r;
    ckind_nxt = ckind_r;
    caddr_nxt = caddr_r;
    cdata_nxt = cdata_r;
    corg_nxt = corg_r;
    case (lst_r)
      L_IDLE: begin
        if (chip_sel && ser_in) begin
          lst_nxt = L_OP;
          cnt_nxt = 5'h00;
          sh_nxt = 16'h0000;
          stgl_nxt = ~stgl_r;
        end
      end
      L_OP: begin
        sh_nxt = shin;
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == OP_LEN - 5'h01) begin
          lst_nxt = L_ADDR;
          cnt_nxt = 5'h00;
        end
      end
      L_ADDR: begin
        sh_nxt = shin;
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == alen - 5'h01) begin
          cnt_nxt = 5'h00;
          caddr_nxt = ad;
          corg_nxt = org_s;
          lst_nxt = L_DONE;
          case (op)
            OP_READ: begin
              rreq_nxt = ~rreq_r;
              raddr_nxt = ad;
              rorg_nxt = org_s;
              lst_nxt = L_RDUM;
            end
            OP_WRITE: begin
              ckind_nxt = K_WRITE;
              lst_nxt = L_DATA;
            end
            OP_ERASE: begin
              ckind_nxt = K_ERASE;
              ctgl_nxt = ~ctgl_r;
            end
            default: begin
              case (ext)
                EXT_EN: ckind_nxt = K_EN;
                EXT_DIS: ckind_nxt = K_DIS;
                EXT_ERASE_ALL_CMD: ckind_nxt = K_ERASE_ALL_CMD;
                default: ckind_nxt = K_WRITE_ALL_CMD;
              endcase
              if (ext == EXT_WRITE_ALL_CMD) begin
                lst_nxt = L_DATA;
              end else begin
                ctgl_nxt = ~ctgl_r;
              end
            end
          endcase
        end
      end
      L_DATA: begin
        sh_nxt = shin;
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == dlen - 5'h01) begin
          cdata_nxt = shin;
          ctgl_nxt = ~ctgl_r;
          lst_nxt = L_DONE;
        end
      end
      L_RDUM: begin
        lq_nxt = 1'b0;
        ldrv_nxt = 1'b1;
        cnt_nxt = 5'h00;
        lst_nxt = L_RDAT;
      end
      L_RDAT: begin
        if (cnt_r == 5'h00) begin
          // A new word is loaded only once its fetch has been answered.
          if (ack_n2_r == rreq_r) begin
            lq_nxt = ld[15];
            sh_nxt = {ld[14:0], 1'b0};
            cnt_nxt = 5'h01;
            rreq_nxt = ~rreq_r;
            raddr_nxt = rorg_r ? {1'b0, raddr_r[6:0] + 7'h01} :
                                 raddr_r + 8'h01;
          end
        end else begin
          lq_nxt = sh_r[15];
          sh_nxt = {sh_r[14:0], 1'b0};
          // No dummy bit between words: the count wraps straight to a load.
          cnt_nxt = (cnt_r == dlen - 5'h01) ? 5'h00 :
                                              cnt_r + 5'h01;
        end
      end
      L_DONE: begin
        lst_nxt = L_DONE;
      end
      default: begin
        lst_nxt = L_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Frame registers, cleared while select is low.
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lst_r <= L_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      lq_r <= 1'b0;
      ldrv_r <= 1'b0;
    end else begin
      lst_r <= lst_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      lq_r <= lq_nxt;
      ldrv_r <= ldrv_nxt;
    end
  end

  // Handshake registers outlive the frame: mclk reads them after select
  // falls, so they must not be cleared with it.
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rreq_r <= 1'b0;
      raddr_r <= 8'h00;
      rorg_r <= 1'b1;
      stgl_r <= 1'b0;
      ctgl_r <= 1'b0;
      ckind_r <= K_DIS;
      caddr_r <= 8'h00;
      cdata_r <= 16'h0000;
      corg_r <= 1'b1;
    end else begin
      rreq_r <= rreq_nxt;
      raddr_r <= raddr_nxt;
      rorg_r <= rorg_nxt;
      stgl_r <= stgl_nxt;
      ctgl_r <= ctgl_nxt;
      ckind_r <= ckind_nxt;
      caddr_r <= caddr_nxt;
      cdata_r <= cdata_nxt;
      corg_r <= corg_nxt;
    end
  end

  // Read acknowledge synchronised on falling sclk edges, so an answer
  // given within half a serial period of the request is usable two rising edges later.
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_n1_r <= 1'b0;
      ack_n2_r <= 1'b0;
    end else begin
      ack_n1_r <= ack_r;
      ack_n2_r <= ack_n1_r;
    end
  end

  // ==========================================================================
  // Crossing of select, toggles and the serial output level into mclk.
  sep_sync #(.W(6), .RST(6'h00)) u_link_sync (
    .clk(mclk),
    .arst_n(arst_n),
    .d({chip_sel, ctgl_r, rreq_r, stgl_r, lq_r, ldrv_r}),
    .q({cs_s, ctgl_s, rreq_s, stgl_s, lq_s, ldrv_s})
  );

  sep_mem u_mem (
    .mclk(mclk),
    .we(mem_we),
    .be(mem_be),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(mem_ra),
    .rdata(mem_rd)
  );

  // ==========================================================================
  // Command execution, programming timer, read service and pin output.
  always_comb begin
    cs_fall = cs_d_r & ~cs_s;
    cmd_ev = ctgl_s ^ ctgl_d_r;
    rd_ev = rreq_s ^ rreq_d_r;
    st_ev = stgl_s ^ stgl_d_r;
    busy = (mst_r != M_IDLE);
    done = 1'b0;
    mst_nxt = mst_r;
    pcnt_nxt = pcnt_r;
    fill_nxt = fill_r;
    fdata_nxt = fdata_r;
    prog_en_nxt = prog_en_r;
    armed_nxt = armed_r;
    mem_we = 1'b0;
    mem_be = sep_be(corg_r, caddr_r);
    mem_wa = sep_idx(corg_r, caddr_r);
    mem_wd = sep_wfmt(corg_r, cdata_r);
    if (cs_fall) begin
      armed_nxt = 1'b0;
    end
    // Commands decoded during a programming cycle are dropped.
    if (cmd_ev && !busy) begin
      case (ckind_r)
        K_EN: prog_en_nxt = 1'b1;
        K_DIS: prog_en_nxt = 1'b0;
        default: armed_nxt = 1'b1;
      endcase
    end
    case (mst_r)
      M_IDLE: begin
        if (cs_fall && armed_r && prog_en_r) begin
          pcnt_nxt = '0;
          fill_nxt = 7'h00;
          case (ckind_r)
            K_WRITE: begin
              mem_we = 1'b1;
              mst_nxt = M_TIME;
            end
            K_ERASE: begin
              mem_we = 1'b1;
              mem_wd = ERASED_WORD;
              mst_nxt = M_TIME;
            end
            K_ERASE_ALL_CMD: begin
              fdata_nxt = ERASED_WORD;
              mst_nxt = M_FILL;
            end
            default: begin
              fdata_nxt = sep_wfmt(corg_r, cdata_r);
              mst_nxt = M_FILL;
            end
          endcase
        end
      end
      M_FILL: begin
        mem_we = 1'b1;
        mem_be = BE_ALL;
        mem_wa = fill_r;
        mem_wd = fdata_r;
        fill_nxt = fill_r + 7'h01;
        if (fill_r == LAST_IDX) begin
          mst_nxt = M_TIME;
        end
      end
      M_TIME: begin
        pcnt_nxt = pcnt_r + 1'b1;
        if (pcnt_r == PCNT_W'(PROG_CYCLES - 1)) begin
          mst_nxt = M_IDLE;
          done = 1'b1;
        end
      end
      default: begin
        mst_nxt = M_IDLE;
      end
    endcase
    // Ready clears on select falling or a start bit; completion wins.
    ready_nxt = ready_r;
    if (cs_fall || st_ev) begin
      ready_nxt = 1'b0;
    end
    if (done) begin
      ready_nxt = 1'b1;
    end
    // Reads need no enable; the link holds the address until answered.
    rd_stage_nxt = rd_ev && !busy;
    mem_ra = sep_idx(rorg_r, raddr_r);
    rdata_nxt = rdata_r;
    ack_nxt = ack_r;
    if (rd_stage_r) begin
      rdata_nxt = rorg_r ? mem_rd :
                  {8'h00, raddr_r[0] ? mem_rd[15:8] : mem_rd[7:0]};
      ack_nxt = ~ack_r;
    end
    // Busy shows as low, then ready as high, while select is high.
    oe_nxt = cs_s & (busy | ready_r | ldrv_s);
    q_nxt = busy ? 1'b0 : (ldrv_s ? lq_s : ready_r);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mst_r <= M_IDLE;
      pcnt_r <= '0;
      fill_r <= 7'h00;
      fdata_r <= 16'h0000;
      prog_en_r <= 1'b0;
      armed_r <= 1'b0;
      ready_r <= 1'b0;
      rd_stage_r <= 1'b0;
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      q_r <= 1'b0;
      oe_r <= 1'b0;
      cs_d_r <= 1'b0;
      ctgl_d_r <= 1'b0;
      rreq_d_r <= 1'b0;
      stgl_d_r <= 1'b0;
    end else begin
      mst_r <= mst_nxt;
      pcnt_r <= pcnt_nxt;
      fill_r <= fill_nxt;
      fdata_r <= fdata_nxt;
      prog_en_r <= prog_en_nxt;
      armed_r <= armed_nxt;
      ready_r <= ready_nxt;
      rd_stage_r <= rd_stage_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      q_r <= q_nxt;
      oe_r <= oe_nxt;
      cs_d_r <= cs_s;
      ctgl_d_r <= ctgl_s;
      rreq_d_r <= rreq_s;
      stgl_d_r <= stgl_s;
    end
  end

  assign ser_out = q_r;
  assign ser_out_oe = oe_r;

  // ==========================================================================
  // Checks on the system-clock side.
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_rd_answered;
    ##2 (ack_r != $past(ack_r));
  endsequence
  sequence s_prog_go;
    cs_fall && armed_r && prog_en_r && !busy;
  endsequence

  property p_rd_any;
    rd_ev && !busy |-> s_rd_answered;
  endproperty
  a_rd_any: assert property (p_rd_any) else $error("read not answered");
  property p_start;
    s_prog_go |=> busy ##0 !ready_r;
  endproperty
  a_start: assert property (p_start) else $error("no program start");
  property p_inhibit;
    $rose(busy) |-> $past(prog_en_r) && $past(cs_fall);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("program w/o enable");
  property p_busy_low;
    busy && cs_s |=> oe_r && !q_r;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy not low");
  property p_ready_clr;
    ready_r && (cs_fall || st_ev) && !done |=> !ready_r;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready stuck");
  property p_fill;
    mst_r == M_FILL && fill_r == LAST_IDX |=> mst_r == M_TIME && pcnt_r == 0;
  endproperty
  a_fill: assert property (p_fill) else $error("fill end wrong");
  property p_ignore;
    busy && cmd_ev |=> $stable(prog_en_r) && !$rose(armed_r);
  endproperty
  a_ignore: assert property (p_ignore) else $error("command while busy");
  property p_erase;
    (s_prog_go and (ckind_r == K_ERASE)) |->
      mem_we && mem_wd == ERASED_WORD;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not ones");

endmodule

/* testbench/sep_host.sv */
// Purpose: Host serial controller model driving select, clock and data.
// Assumes: Serial clock phases of 500 ns, far slower than the system clock.
// Notes: The serial clock stands low outside frames.
`timescale 1ns/10ps
module sep_host (
  input wire logic mclk,
  input wire logic pin,
  output logic sclk,
  output logic chip_sel,
  output logic ser_in
);
  // ==========================================================================
  // Link timing
  localparam int HALF = 50;

  // Idle levels; the link is quiet until a frame is requested.
  initial begin
    sclk = 1'b0;
    chip_sel = 1'b0;
    ser_in = 1'b0;
  end

  // Moves the select line alone, used for the busy and ready display.
  task automatic select(input logic v);
    @(posedge mclk);
    chip_sel <= v;
  endtask

  // Sends nb bits MSB first, then ne idle edges, sampling the pin just
  // before each rising edge so read bits are taken where they settled.
  task automatic frame(input int nb, input logic [31:0] bits,
                       input int ne, output logic [63:0] rd);
    rd = '0;
    @(posedge mclk);
    chip_sel <= 1'b1;
    for (int i = nb - 1; i >= -ne; i--) begin
      ser_in <= (i >= 0) ? bits[i] : 1'b0;
      repeat (HALF - 1) @(posedge mclk);
      @(negedge mclk);
      rd = {rd[62:0], pin};
      @(posedge mclk);
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    chip_sel <= 1'b0;
    // A 300 ns gap keeps frames apart by more than the minimum.
    repeat (30) @(posedge mclk);
  endtask
endmodule

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the serial EEPROM command port.
// Assumes: Programming time shortened to 1500 system clocks, still longer
//          than one short frame so a command can land inside a busy cycle.
// Notes: A released output pin shows the inverse of its last level.
`timescale 1ns/10ps
module testbench;
  // ==========================================================================
  // Signals
  logic mclk, arst_n, org_word, ser_out, ser_out_oe, last_q;
  logic sclk, chip_sel, ser_in;
  wire logic pin;
  logic [63:0] rd;
  int n_mismatch = 0;
  int checks_done = 0;

  // The pin is undriven when disabled; show the opposite level, not a guess.
  assign pin = ser_out_oe ? ser_out : ~last_q;
  always @(posedge mclk) begin
    if (ser_out_oe) begin
      last_q <= ser_out;
    end
  end

  sep_core #(.PROG_CYCLES(1500)) uut (.mclk(mclk), .arst_n(arst_n),
    .sclk(sclk), .chip_sel(chip_sel), .ser_in(ser_in),
    .org_word(org_word), .ser_out(ser_out), .ser_out_oe(ser_out_oe));
  sep_host host (.mclk(mclk), .pin(pin), .sclk(sclk),
    .chip_sel(chip_sel), .ser_in(ser_in));

  // ==========================================================================
  // Helpers
  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Raises select after a programming frame, expects busy, then ready.
  task automatic prog_wait();
    int n;
    n = 0;
    host.select(1'b1);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(pin, 1'b0);
    while (pin !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    chk(pin, 1'b1);
    if (n >= 2000) begin
      give_verdict();
    end
    host.select(1'b0);
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk(ser_out_oe, 1'b0);
    repeat (30) @(posedge mclk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_setup();
    host.frame(11, {3'b100, 8'hc0}, 0, rd);
    host.frame(11, {3'b100, 8'h80}, 0, rd);
    prog_wait();
    host.frame(11, {3'b110, 8'h05}, 18, rd);
    chk(rd[16:0], {1'b0, 16'hffff});
  endtask

  task automatic t_refuse();
    host.frame(11, {3'b100, 8'h00}, 0, rd);
    host.frame(27, {3'b101, 8'h05, 16'h1234}, 0, rd);
    repeat (100) @(posedge mclk);
    host.frame(11, {3'b110, 8'h05}, 18, rd);
    chk(rd[16:0], {1'b0, 16'hffff});
  endtask

  task automatic t_write();
    host.frame(11, {3'b100, 8'hc0}, 0, rd);
    host.frame(27, {3'b101, 8'h05, 16'h1234}, 0, rd);
    prog_wait();
    host.frame(11, {3'b110, 8'h05}, 34, rd);
    chk(rd[32:0], {1'b0, 16'h1234, 16'hffff});
  endtask

  task automatic t_erase();
    host.frame(11, {3'b111, 8'h05}, 0, rd);
    prog_wait();
    host.frame(11, {3'b110, 8'h05}, 18, rd);
    chk(rd[16:0], {1'b0, 16'hffff});
  endtask

  task automatic t_write_all_cmd();
    host.frame(27, {3'b100, 8'h40, 16'ha5a5}, 0, rd);
    prog_wait();
    host.frame(11, {3'b110, 8'h7f}, 34, rd);
    chk(rd[32:0], {1'b0, 16'ha5a5, 16'ha5a5});
  endtask

  // A disable that ends while a write is timing must be dropped.
  task automatic t_busy();
    host.frame(27, {3'b101, 8'h05, 16'h5a5a}, 0, rd);
    host.frame(11, {3'b100, 8'h00}, 0, rd);
    prog_wait();
    host.frame(11, {3'b110, 8'h05}, 18, rd);
    chk(rd[16:0], {1'b0, 16'h5a5a});
  endtask

  // A mid-run reset stands for power-up: programming is refused again.
  task automatic t_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({ser_out_oe, ser_out}, 2'b00);
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    host.frame(27, {3'b101, 8'h05, 16'h0000}, 0, rd);
    repeat (100) @(posedge mclk);
    host.frame(11, {3'b110, 8'h05}, 18, rd);
    chk(rd[16:0], {1'b0, 16'ha5a5});
  endtask

  // Byte organisation: nine address bits and eight data bits.
  task automatic t_byte();
    @(posedge mclk);
    org_word <= 1'b0;
    host.frame(12, {3'b100, 9'h180}, 0, rd);
    host.frame(20, {3'b101, 9'h003, 8'h3c}, 0, rd);
    prog_wait();
    host.frame(12, {3'b110, 9'h002}, 18, rd);
    chk(rd[16:0], {1'b0, 8'ha5, 8'h3c});
    host.frame(12, {3'b100, 9'h000}, 0, rd);
  endtask

  // ==========================================================================
  // Clock, reset and main sequence
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    arst_n = 1'b0;
    org_word = 1'b1;
    last_q = 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_setup();
    t_refuse();
    t_write();
    t_busy();
    t_erase();
    t_write_all_cmd();
    t_reset();
    t_byte();
    give_verdict();
  end
endmodule
